// ==== design/pws_pkg.sv ====
package pws_pkg;
   localparam int CNT_W = 16;
   localparam int PRE_W = 8;
   localparam int SEL_W = 3;
   localparam int LVL_W = 3;
   localparam logic [15:0] CNT_START = 16'h0001;
   localparam logic [15:0] WIDTH_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'h0000;
   localparam logic [15:0] WIDTH_ZERO = 16'h0000;
   localparam logic [15:0] PERIOD_FULL = 16'h0000;
   localparam logic [2:0] LVL_OFF = 3'h0;
   // system clock divide ratio minus one, for the two settings
   localparam logic [1:0] DIV2_LAST = 2'h1;
   localparam logic [1:0] DIV3_LAST = 2'h2;
   localparam logic [2:0] SEL_SLOWEST = 3'h7;
   localparam logic [7:0] MASK_SLOWEST = 8'hff;
endpackage : pws_pkg

// ==== design/pws_prescale.sv ====
module pws_prescale (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic clr,
   input wire logic div3,
   input wire logic [pws_pkg::SEL_W-1:0] clk_sel,
   output logic tick
);
   typedef struct packed {
      logic [1:0] div_cnt;
      logic [pws_pkg::PRE_W-1:0] pre_cnt;
      logic tick;
   } pws_pre_s;

   pws_pre_s st_ff;
   pws_pre_s nxt_st;

   always_comb begin
      logic pclk;
      logic [pws_pkg::PRE_W-1:0] mask;
      pclk = 1'b0;
      mask = '0;
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (clr) begin
         nxt_st.div_cnt = '0;
         nxt_st.pre_cnt = '0;
      end else begin
         // first stage: system clock over 2 or 3
         pclk = (st_ff.div_cnt == (div3 ? pws_pkg::DIV3_LAST : pws_pkg::DIV2_LAST));
         nxt_st.div_cnt = pclk ? 2'h0 : 2'(st_ff.div_cnt + 2'h1);
         if (pclk) begin
            if (clk_sel == pws_pkg::SEL_SLOWEST) begin
               mask = pws_pkg::MASK_SLOWEST;
            end else begin
               mask = 8'((8'h01 << clk_sel) - 8'h01);
            end
            nxt_st.tick = ((st_ff.pre_cnt & mask) == mask);
            nxt_st.pre_cnt = 8'(st_ff.pre_cnt + 8'h01);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;
endmodule : pws_prescale

// ==== design/pws_pulse.sv ====
module pws_pulse (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic enable,
   input wire logic polarity,
   input wire logic div3,
   input wire logic [pws_pkg::SEL_W-1:0] clk_sel,
   input wire logic [pws_pkg::LVL_W-1:0] irq_priority_level,
   input wire logic freeze,
   input wire logic load_strobe,
   input wire logic wr_width,
   input wire logic wr_period,
   input wire logic wr_long,
   input wire logic [pws_pkg::CNT_W-1:0] wdata_width,
   input wire logic [pws_pkg::CNT_W-1:0] wdata_period,
   input wire logic flag_read,
   input wire logic flag_clear_wr,
   output logic pwm_pin,
   output logic [pws_pkg::CNT_W-1:0] counter_value,
   output logic [pws_pkg::CNT_W-1:0] next_width_reg,
   output logic [pws_pkg::CNT_W-1:0] next_period_reg,
   output logic flag,
   output logic irq_req,
   output logic [pws_pkg::LVL_W-1:0] irq_level_out
);
   typedef struct packed {
      logic [pws_pkg::CNT_W-1:0] next_w;
      logic [pws_pkg::CNT_W-1:0] next_p;
      logic [pws_pkg::CNT_W-1:0] act_w;
      logic [pws_pkg::CNT_W-1:0] act_p;
      logic [pws_pkg::CNT_W-1:0] cnt;
      logic out;
      logic pin;
      logic flag;
      logic armed;
      logic irq;
      logic [pws_pkg::LVL_W-1:0] lvl;
      logic en_q;
   } pws_state_s;

   pws_state_s st_ff;
   pws_state_s nxt_st;
   logic tick;
   logic full;
   logic en_rise;
   logic bnd;
   logic set_evt;
   logic [pws_pkg::CNT_W-1:0] new_w;

   // prescaler held cleared while disabled or reloaded
   pws_prescale u_clock_prescale_unit (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .clr(!enable || !st_ff.en_q || load_strobe),
      .div3(div3),
      .clk_sel(clk_sel),
      .tick(tick)
   );

   // a period register of zero means 65536 prescaler ticks, never full duty
   assign full = (st_ff.act_p != pws_pkg::PERIOD_FULL) && (st_ff.act_w >= st_ff.act_p);
   assign en_rise = enable && !st_ff.en_q;
   assign bnd = enable && st_ff.en_q && !load_strobe && tick && !freeze && (st_ff.cnt == st_ff.act_p);
   assign set_evt = en_rise || bnd;
   // a long write landing on the boundary keeps the old active pair
   assign new_w = (bnd && wr_long) ? st_ff.act_w : st_ff.next_w;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.en_q = enable;
      if (wr_long) begin
         nxt_st.next_w = wdata_width;
         nxt_st.next_p = wdata_period;
      end else begin
         if (wr_width) begin
            nxt_st.next_w = wdata_width;
         end
         if (wr_period) begin
            nxt_st.next_p = wdata_period;
         end
      end
      if (!enable) begin
         // disabled: buffers follow the next registers continuously
         nxt_st.act_w = st_ff.next_w;
         nxt_st.act_p = st_ff.next_p;
         nxt_st.cnt = pws_pkg::CNT_START;
         nxt_st.out = 1'b0;
      end else if (en_rise || load_strobe) begin
         nxt_st.act_w = st_ff.next_w;
         nxt_st.act_p = st_ff.next_p;
         nxt_st.cnt = pws_pkg::CNT_START;
         nxt_st.out = (st_ff.next_w != pws_pkg::WIDTH_ZERO);
      end else if (tick && !freeze) begin
         if (bnd) begin
            if (!wr_long) begin
               nxt_st.act_w = st_ff.next_w;
               nxt_st.act_p = st_ff.next_p;
            end
            nxt_st.cnt = pws_pkg::CNT_START;
            nxt_st.out = (new_w != pws_pkg::WIDTH_ZERO);
         end else begin
            nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
            if ((st_ff.cnt == st_ff.act_w) && !full) begin
               nxt_st.out = 1'b0;
            end
         end
      end
      // flag: read as one arms a clear; any set in between wins
      if (!enable) begin
         nxt_st.flag = 1'b0;
         nxt_st.armed = 1'b0;
      end else if (set_evt) begin
         nxt_st.flag = 1'b1;
         nxt_st.armed = 1'b0;
      end else if (flag_clear_wr) begin
         nxt_st.flag = st_ff.armed ? 1'b0 : st_ff.flag;
         nxt_st.armed = 1'b0;
      end else if (flag_read && st_ff.flag) begin
         nxt_st.armed = 1'b1;
      end
      nxt_st.lvl = irq_priority_level;
      nxt_st.irq = nxt_st.flag && (irq_priority_level != pws_pkg::LVL_OFF);
      nxt_st.pin = nxt_st.out ^ polarity;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff.next_w <= pws_pkg::WIDTH_RESET;
         st_ff.next_p <= pws_pkg::PERIOD_RESET;
         st_ff.act_w <= pws_pkg::WIDTH_RESET;
         st_ff.act_p <= pws_pkg::PERIOD_RESET;
         st_ff.cnt <= pws_pkg::CNT_START;
         st_ff.out <= 1'b0;
         st_ff.pin <= 1'b0;
         st_ff.flag <= 1'b0;
         st_ff.armed <= 1'b0;
         st_ff.irq <= 1'b0;
         st_ff.lvl <= pws_pkg::LVL_OFF;
         st_ff.en_q <= 1'b0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign pwm_pin = st_ff.pin;
   assign counter_value = st_ff.cnt;
   assign next_width_reg = st_ff.next_w;
   assign next_period_reg = st_ff.next_p;
   assign flag = st_ff.flag;
   assign irq_req = st_ff.irq;
   assign irq_level_out = st_ff.lvl;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b || !clk_en);

   AST_NEXT_WIDTH_HELD: assert property (
      (!wr_width && !wr_long) |=> (next_width_reg == $past(next_width_reg)))
      else $error("next width changed without a write");

   AST_DISABLED_PIN: assert property (
      (!enable ##1 !enable) |=> (pwm_pin == $past(polarity)))
      else $error("disabled pin does not follow polarity");

   AST_ZERO_WIDTH: assert property (
      (enable && st_ff.en_q && !load_strobe && !bnd && st_ff.act_w == pws_pkg::WIDTH_ZERO && !st_ff.out)
      |=> !st_ff.out)
      else $error("zero width output left cleared state");

   AST_FULL_HOLD: assert property (
      (enable && st_ff.en_q && !load_strobe && !bnd && full && st_ff.out) |=> st_ff.out)
      else $error("full width output dropped mid period");

   AST_RESTART: assert property (
      bnd |=> (counter_value == pws_pkg::CNT_START) && (st_ff.out == ($past(new_w) != pws_pkg::WIDTH_ZERO)))
      else $error("period match did not restart counter and output");

   AST_WIDTH_MATCH: assert property (
      (tick && !freeze && enable && st_ff.en_q && !load_strobe && !bnd && st_ff.cnt == st_ff.act_w && !full)
      |=> !st_ff.out && (counter_value == 16'($past(counter_value) + 16'h0001)))
      else $error("width match wrong output or disturbed counter");

   AST_FLAG_SET: assert property (
      set_evt |=> flag ##0 (irq_req == (irq_level_out != pws_pkg::LVL_OFF)))
      else $error("period start did not set flag and request");

   AST_FREEZE_HOLD: assert property (
      (freeze && enable && st_ff.en_q && !load_strobe) |=> (counter_value == $past(counter_value)))
      else $error("counter moved during freeze");

   AST_LONG_SKIP: assert property (
      (bnd && wr_long) |=> (st_ff.act_w == $past(st_ff.act_w)) && (st_ff.act_p == $past(st_ff.act_p)))
      else $error("long write at period end did not skip transfer");

   AST_ENABLE_RISE: assert property (
      (en_rise && st_ff.next_w != pws_pkg::WIDTH_ZERO) |=> st_ff.out && flag && (counter_value == pws_pkg::CNT_START))
      else $error("enable rise did not start first pulse");

   AST_SET_BEATS_CLEAR: assert property (
      (flag_clear_wr && set_evt) |=> flag)
      else $error("clear won over a set event");

   COV_BOUNDARY: cover property (bnd ##[1:300] bnd);
   COV_FLAG_CLEARED: cover property (flag && flag_read ##1 flag_clear_wr ##1 !flag);
   COV_LONG_SKIP: cover property (bnd && wr_long);
   AST_OUT_CLEARED_DISABLED: assert property (
      !enable |=> !st_ff.out)
      else $error("output flip-flop set while disabled");

   AST_CNT_HELD_DISABLED: assert property (
      !enable |=> (counter_value == pws_pkg::CNT_START))
      else $error("counter not held at one while disabled");

   AST_FLAG_CLEAR_DISABLED: assert property (
      !enable |=> !flag)
      else $error("flag set while disabled");

   AST_BUF_FOLLOW_DISABLED: assert property (
      !enable |=> (st_ff.act_w == $past(st_ff.next_w)) && (st_ff.act_p == $past(st_ff.next_p)))
      else $error("buffers did not follow next registers while disabled");

   AST_NEXT_PERIOD_HELD: assert property (
      (!wr_period && !wr_long) |=> (next_period_reg == $past(next_period_reg)))
      else $error("next period changed without a write");

   AST_WIDTH_WRITE: assert property (
      (wr_width && !wr_long) |=> (next_width_reg == $past(wdata_width)))
      else $error("width write not stored");

   AST_LONG_WRITE: assert property (
      wr_long |=> (next_width_reg == $past(wdata_width)) && (next_period_reg == $past(wdata_period)))
      else $error("long write did not store both values");

   AST_LOAD_TRANSFER: assert property (
      (enable && st_ff.en_q && load_strobe) |=> (st_ff.act_w == $past(st_ff.next_w))
      && (st_ff.act_p == $past(st_ff.next_p)) && (counter_value == pws_pkg::CNT_START))
      else $error("load did not transfer and restart");

   AST_LOAD_OUT: assert property (
      (enable && st_ff.en_q && load_strobe) |=> (st_ff.out == ($past(st_ff.next_w) != pws_pkg::WIDTH_ZERO)))
      else $error("load gave wrong output level");

   AST_ACT_STABLE_MID: assert property (
      (enable && st_ff.en_q && !load_strobe && !bnd) |=> (st_ff.act_w == $past(st_ff.act_w))
      && (st_ff.act_p == $past(st_ff.act_p)))
      else $error("active buffers changed inside a period");

   AST_PAIR_TRANSFER: assert property (
      (bnd && !wr_long) |=> (st_ff.act_w == $past(st_ff.next_w)) && (st_ff.act_p == $past(st_ff.next_p)))
      else $error("period and width not transferred together");

   AST_NO_TICK_HOLD: assert property (
      (enable && st_ff.en_q && !load_strobe && !tick) |=> (counter_value == $past(counter_value)))
      else $error("counter moved without a prescaler tick");

   AST_COUNT_STEP: assert property (
      (tick && !freeze && enable && st_ff.en_q && !load_strobe && !bnd)
      |=> (counter_value == 16'($past(counter_value) + 16'h0001)))
      else $error("counter did not step by one");

   AST_OUT_NO_RISE_MID: assert property (
      (enable && st_ff.en_q && !load_strobe && !bnd && !st_ff.out) |=> !st_ff.out)
      else $error("output set again inside a period");

   AST_OUT_FALL_ONLY_MATCH: assert property (
      (enable && st_ff.en_q && !load_strobe && !bnd && st_ff.out && !(tick && !freeze && st_ff.cnt == st_ff.act_w))
      |=> st_ff.out)
      else $error("output cleared without a width match");

   AST_PIN_POLARITY: assert property (
      1'b1 |=> (pwm_pin == (st_ff.out ^ $past(polarity))))
      else $error("pin does not follow output and polarity");

   AST_IRQ_GATED_OFF: assert property (
      (irq_level_out == pws_pkg::LVL_OFF) |-> !irq_req)
      else $error("request raised at level zero");

   AST_IRQ_FOLLOWS_FLAG: assert property (
      (irq_level_out != pws_pkg::LVL_OFF) |-> (irq_req == flag))
      else $error("request does not follow flag");

   AST_FLAG_STICKY: assert property (
      (flag && !flag_clear_wr && enable) |=> flag)
      else $error("flag dropped without a clear");

   AST_CLEAR_NEEDS_READ: assert property (
      (enable && flag && flag_clear_wr && !st_ff.armed) |=> flag)
      else $error("flag cleared without a prior read");

   AST_FLAG_NO_SELF_SET: assert property (
      (!flag && !set_evt) |=> !flag)
      else $error("flag set without a period start");

   AST_ARM_ON_READ: assert property (
      (enable && !set_evt && !flag_clear_wr && flag_read && flag) |=> st_ff.armed)
      else $error("read of set flag did not arm clear");

   AST_ZERO_ON_BOUNDARY: assert property (
      (bnd && !wr_long && st_ff.next_w == pws_pkg::WIDTH_ZERO) |=> !st_ff.out)
      else $error("zero width period started with output set");

   AST_FREEZE_OUT_HOLD: assert property (
      (freeze && enable && st_ff.en_q && !load_strobe) |=> (st_ff.out == $past(st_ff.out)))
      else $error("output changed during freeze");

   AST_LONG_PERIOD_MATCH: assert property (
      (tick && !freeze && enable && st_ff.en_q && !load_strobe && st_ff.act_p == pws_pkg::PERIOD_FULL
      && st_ff.cnt == st_ff.act_w && st_ff.act_w != pws_pkg::WIDTH_ZERO) |=> !st_ff.out)
      else $error("longest period reached full duty");

   AST_ENABLE_RISE_ZERO: assert property (
      (en_rise && st_ff.next_w == pws_pkg::WIDTH_ZERO) |=> !st_ff.out && flag)
      else $error("enable rise with zero width set output");

   AST_TRANSFER_ON_RISE: assert property (
      en_rise |=> (st_ff.act_w == $past(st_ff.next_w)) && (st_ff.act_p == $past(st_ff.next_p)))
      else $error("enable rise did not transfer buffers");

   COV_FULL_DUTY: cover property (enable && full && st_ff.out);
   COV_LOAD: cover property (enable && st_ff.en_q && load_strobe);
endmodule : pws_pulse

// ==== tb/pwm_pulse_width_section_bench.sv ====
module pwm_pulse_width_section_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, clk_en, enable, polarity, div3, freeze, load_strobe;
   logic wr_width, wr_period, wr_long, flag_read, flag_clear_wr;
   logic [pws_pkg::SEL_W-1:0] clk_sel;
   logic [pws_pkg::LVL_W-1:0] lvl;
   logic [pws_pkg::CNT_W-1:0] wdata_width, wdata_period;
   logic pwm_pin, flag, irq_req;
   logic [pws_pkg::CNT_W-1:0] counter_value, next_width_reg, next_period_reg;
   logic [pws_pkg::LVL_W-1:0] irq_level_out;
   int errors, check_count;

   pws_pulse DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .enable(enable), .polarity(polarity), .div3(div3),
      .clk_sel(clk_sel), .irq_priority_level(lvl), .freeze(freeze), .load_strobe(load_strobe),
      .wr_width(wr_width), .wr_period(wr_period), .wr_long(wr_long), .wdata_width(wdata_width),
      .wdata_period(wdata_period), .flag_read(flag_read), .flag_clear_wr(flag_clear_wr), .pwm_pin(pwm_pin),
      .counter_value(counter_value), .next_width_reg(next_width_reg), .next_period_reg(next_period_reg),
      .flag(flag), .irq_req(irq_req), .irq_level_out(irq_level_out));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic test_done();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   // pulse wr_long, or both wr_width and wr_period, for one cycle
   task automatic write_next(input logic [15:0] w, input logic [15:0] p, input logic as_long);
      @(posedge clk);
      wdata_width <= w;
      wdata_period <= p;
      if (as_long) wr_long <= 1'b1;
      else begin
         wr_width <= 1'b1;
         wr_period <= 1'b1;
      end
      @(posedge clk);
      wr_long <= 1'b0;
      wr_width <= 1'b0;
      wr_period <= 1'b0;
   endtask : write_next

   // cycles the true output level stays at lv, bounded
   task automatic run_len(input logic lv, output int c);
      c = 0;
      while (((pwm_pin ^ polarity) === lv) && c < 3000) begin
         @(negedge clk);
         c++;
      end
   endtask : run_len

   function automatic int ratio(input logic d3, input logic [2:0] sel);
      return (d3 ? 3 : 2) << sel;
   endfunction : ratio

   initial begin
      int w, p, r, hi, lo, d, bad, i;
      logic [15:0] c;
      int tw[4] = '{1, 3, 0, 9};
      int tp[4] = '{2, 4, 5, 6};
      void'($urandom(32'hfdb7419e));
      {rst_b, enable, polarity, div3, freeze, load_strobe} = '0;
      {wr_width, wr_period, wr_long, flag_read, flag_clear_wr} = '0;
      clk_en = 1'b1;
      clk_sel = '0;
      lvl = 3'($urandom_range(7, 1));
      wdata_width = '0;
      wdata_period = '0;
      repeat (12) @(posedge clk);
      check("counter", 32'h1, counter_value);
      check("pin", 32'h0, pwm_pin);
      check("flag", 32'h0, flag);
      rst_b <= 1'b1;
      write_next(16'h0005, 16'h000a, 1'b0);
      repeat (5) @(negedge clk);
      check("disabled counter", 32'h1, counter_value);
      check("disabled flag", 32'h0, flag);
      @(posedge clk);
      enable <= 1'b1;
      repeat (2) @(negedge clk);
      check("flag on enable", 32'h1, flag);
      check("counter on enable", 32'h1, counter_value);
      check("pin on enable", 32'h1, pwm_pin ^ polarity);
      check("irq", 32'h1, irq_req);
      check("irq level", 32'(lvl), irq_level_out);
      for (i = 0; i < 14; i++) begin
         p = (i < 4) ? tp[i] : $urandom_range(16, 2);
         w = (i < 4) ? tw[i] : $urandom_range(p + 1, 0);
         if (i == 13) begin
            w = 1;
            p = 4;
         end
         @(posedge clk);
         div3 <= 1'($urandom_range(1, 0));
         clk_sel <= 3'($urandom_range(1, 0));
         polarity <= 1'($urandom_range(1, 0));
         write_next(16'(w), 16'(p), i[0]);
         @(negedge clk);
         check("next width", 32'(w), next_width_reg);
         check("next period", 32'(p), next_period_reg);
         r = ratio(div3, clk_sel);
         if (w == 0 || w >= p) begin
            repeat (200) @(negedge clk);
            bad = 0;
            repeat (3 * p * r) begin
               @(negedge clk);
               if ((pwm_pin ^ polarity) !== (w != 0)) bad++;
            end
            check("steady output glitches", 32'h0, 32'(bad));
         end else begin
            run_len(1'b1, d);
            run_len(1'b0, d);
            run_len(1'b1, hi);
            run_len(1'b0, lo);
            check("pulse clocks", 32'(w * r), 32'(hi));
            check("period clocks", 32'(p * r), 32'(hi + lo));
         end
         check("next width kept", 32'(w), next_width_reg);
      end
      @(posedge clk);
      freeze <= 1'b1;
      repeat (3) @(negedge clk);
      c = counter_value;
      repeat (20) @(negedge clk);
      check("frozen counter", 32'(c), counter_value);
      @(posedge clk);
      flag_read <= 1'b1;
      @(posedge clk);
      flag_read <= 1'b0;
      flag_clear_wr <= 1'b1;
      @(posedge clk);
      flag_clear_wr <= 1'b0;
      repeat (2) @(negedge clk);
      check("flag cleared", 32'h0, flag);
      check("irq cleared", 32'h0, irq_req);
      check("still frozen", 32'(c), counter_value);
      @(posedge clk);
      freeze <= 1'b0;
      repeat (6 * r) @(negedge clk);
      check("flag at boundary", 32'h1, flag);
      write_next(16'h0003, 16'h0008, 1'b0);
      @(posedge clk);
      load_strobe <= 1'b1;
      @(posedge clk);
      load_strobe <= 1'b0;
      @(negedge clk);
      check("counter on load", 32'h1, counter_value);
      check("pin on load", 32'h1, pwm_pin ^ polarity);
      run_len(1'b1, hi);
      // first tick after a load comes one system clock late
      check("loaded pulse", 32'(3 * r + 1), 32'(hi));
      @(posedge clk);
      enable <= 1'b0;
      repeat (3) @(negedge clk);
      check("idle pin", 32'(polarity), pwm_pin);
      check("idle flag", 32'h0, flag);
      test_done();
   end

   initial begin
      #(100 * 80000);
      errors++;
      test_done();
   end
endmodule : pwm_pulse_width_section_bench
